// File: gfm_top.sv
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module gfm_top
  import gfm_pkg::*;
(
  input wire logic hclk, // system clock
  input wire logic hresetn, // power-on reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write not read
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  input wire gfm_cfg_t otp_image, // one-time configuration image
  input wire logic [GFM_NPIN-1:0] gpio_in, // pin levels
  output logic [GFM_NPIN-1:0] gpio_out, // pin drive values
  output logic [GFM_NPIN-1:0] gpio_oe, // pin drive enables
  input wire logic device_irq, // device interrupt level
  input wire gfm_ind_t ref_ind, // reference monitor indicators
  output gfm_eff_t eff // effective control functions
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  gfm_cfg_t cfg;
  logic loaded;
  logic wr_pend;
  logic [7:0] wr_addr;

  ////////////////////////////////////////////////////////////////////////////
  // returns {drive, level} for a status code
  // every input is an argument, so the calling assign follows its changes
  function automatic logic [1:0] status_sel(
    input logic [6:0] c,
    input logic irq,
    input gfm_ind_t ind,
    input logic [GFM_NREF-1:0] fail
  );
    logic [1:0] r;
    r = 2'b00;
    // pin acts as host interrupt output
    if (c == GFM_ST_IRQ) begin
      r = {1'b1, irq};
    end
    for (int k = 0; k < GFM_NREF; k++) begin
      if (c == GFM_ST_SCM0 + GFM_ST_REF_STEP * 7'(k)) begin
        r = {1'b1, ind.single_cycle_check[k]};
      end
      if (c == GFM_ST_CFM0 + GFM_ST_REF_STEP * 7'(k)) begin
        r = {1'b1, ind.coarse_frequency_check[k]};
      end
      if (c == GFM_ST_GST0 + GFM_ST_REF_STEP * 7'(k)) begin
        r = {1'b1, ind.guard_soak_timer[k]};
      end
      if (c == GFM_ST_FAIL0 + GFM_ST_REF_STEP * 7'(k)) begin
        r = {1'b1, fail[k]};
      end
    end
    return r;
  endfunction : status_sel

  ////////////////////////////////////////////////////////////////////////////
  // per-pin control decode
  logic [GFM_NFN-1:0] pin_hit [GFM_NPIN];
  logic [GFM_NPIN-1:0] st_valid;
  logic [GFM_NPIN-1:0] st_val;
  logic [GFM_NREF-1:0] ref_fail;
  gfm_eff_t pin_eff;

  genvar gi, gb;
  generate
    for (gi = 0; gi < GFM_NPIN; gi++) begin : g_pin
      wire [6:0] code = cfg.pin_cfg[gi][GFM_CODE_MSB:0];
      wire ctl_mode = !cfg.pin_cfg[gi][GFM_STAT_BIT];
      for (gb = 0; gb < GFM_NFN; gb++) begin : g_fn
        // only listed codes hit, others inert
        assign pin_hit[gi][gb] = ctl_mode && (code == GFM_FN_CODE[gb]) && gpio_in[gi];
      end
      assign {st_valid[gi], st_val[gi]} =
        !ctl_mode ? status_sel(code, device_irq, ref_ind, ref_fail) : 2'b00;
    end
  endgenerate

  // or every pin's contribution together
  always_comb begin
    logic [GFM_NFN-1:0] acc;
    acc = '0;
    for (int i = 0; i < GFM_NPIN; i++) begin
      acc = acc | pin_hit[i];
    end
    pin_eff = gfm_eff_t'(acc);
  end

  // per-reference failure, each indicator gated by its mask bit
  generate
    for (gi = 0; gi < GFM_NREF; gi++) begin : g_ref
      wire [3:0] ind = {ref_ind.guard_soak_timer[gi], ref_ind.coarse_frequency_check[gi],
                        ref_ind.single_cycle_check[gi], pin_eff.ref_los[gi]};
      assign ref_fail[gi] = |(ind & cfg.fail_mask[4*gi +: 4]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // effective functions: pin levels or-ed with register bits, except ref_los, which comes from the pins alone
  gfm_eff_t next_eff;
  assign next_eff.ref_los = pin_eff.ref_los;
  assign next_eff.tie_clear = pin_eff.tie_clear | cfg.tie_clear;
  assign next_eff.stop_clk = pin_eff.stop_clk | cfg.stop_clk;
  assign next_eff.diff_en = pin_eff.diff_en | cfg.diff_en;
  assign next_eff.se_en = pin_eff.se_en | cfg.se_en;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire addr_ph = hsel && hready && htrans[1] && loaded;
  wire [7:0] a_off = {haddr[7:2], 2'b00};
  wire a_hi_ok = (haddr[31:8] == 24'h000000);
  wire a_is_pin = a_hi_ok && (a_off <= GFM_OFF_PIN_LAST);
  wire [2:0] a_pin = a_off[4:2];
  wire [2:0] w_pin = wr_addr[4:2];
  wire w_is_pin = wr_addr <= GFM_OFF_PIN_LAST;

  // read multiplexer, unmapped reads as zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    if (a_is_pin) begin
      rd_mux = {24'h000000, cfg.pin_cfg[a_pin]};
    end else if (a_hi_ok) begin
      unique case (a_off)
        GFM_OFF_LOOP: rd_mux = {30'h0, cfg.tie_clear};
        GFM_OFF_STOP: rd_mux = {24'h000000, cfg.stop_clk};
        GFM_OFF_DIFF: rd_mux = {24'h000000, cfg.diff_en};
        GFM_OFF_SE: rd_mux = {28'h0000000, cfg.se_en};
        GFM_OFF_MASK: rd_mux = {16'h0000, cfg.fail_mask};
        GFM_OFF_EFF: rd_mux = {6'h0, eff};
        GFM_OFF_PIN_IN: rd_mux = {24'h000000, gpio_in};
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  // write path into configuration
  gfm_cfg_t next_cfg;
  always_comb begin
    next_cfg = cfg;
    if (!loaded) begin
      next_cfg = otp_image;
    end else if (wr_pend) begin
      if (w_is_pin) begin
        next_cfg.pin_cfg[w_pin] = hwdata[7:0];
      end else begin
        unique case (wr_addr)
          GFM_OFF_LOOP: next_cfg.tie_clear = hwdata[1:0];
          GFM_OFF_STOP: next_cfg.stop_clk = hwdata[7:0];
          GFM_OFF_DIFF: next_cfg.diff_en = hwdata[7:0];
          GFM_OFF_SE: next_cfg.se_en = hwdata[3:0];
          GFM_OFF_MASK: next_cfg.fail_mask = hwdata[15:0];
          default: next_cfg = cfg;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration resets to plain inputs, then loads
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg <= GFM_CFG_RST;
      loaded <= 1'b0;
    end else begin
      cfg <= next_cfg;
      loaded <= 1'b1;
    end
  end

  // bus phase registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      wr_pend <= addr_ph && hwrite && a_hi_ok;
      wr_addr <= a_off;
      hrdata <= (addr_ph && !hwrite) ? rd_mux : 32'h00000000;
      hreadyout <= loaded;
      hresp <= 1'b0;
    end
  end

  // registered pin and function outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gpio_out <= '0;
      gpio_oe <= '0;
      eff <= '0;
    end else begin
      gpio_out <= st_val & st_valid;
      gpio_oe <= st_valid;
      eff <= next_eff;
    end
  end

endmodule : gfm_top
`default_nettype wire

// File: gfm_pkg.sv
package gfm_pkg;
  // pin count and field layout of a pin configuration byte
  localparam int GFM_NPIN = 8;
  localparam int GFM_NREF = 4;
  localparam int GFM_CODE_MSB = 6;
  localparam int GFM_STAT_BIT = 7;
  localparam logic [6:0] GFM_CODE_NONE = 7'h00;

  // register byte offsets
  localparam logic [7:0] GFM_OFF_PIN0 = 8'h00;
  localparam logic [7:0] GFM_OFF_LOOP = 8'h20;
  localparam logic [7:0] GFM_OFF_STOP = 8'h24;
  localparam logic [7:0] GFM_OFF_DIFF = 8'h28;
  localparam logic [7:0] GFM_OFF_SE = 8'h2C;
  localparam logic [7:0] GFM_OFF_MASK = 8'h30;
  localparam logic [7:0] GFM_OFF_EFF = 8'h34;
  localparam logic [7:0] GFM_OFF_PIN_IN = 8'h38;
  localparam logic [7:0] GFM_OFF_PIN_LAST = 8'h1C;

  // status codes with the mode bit stripped
  localparam logic [6:0] GFM_ST_IRQ = 7'h00;
  localparam logic [6:0] GFM_ST_SCM0 = 7'h09;
  localparam logic [6:0] GFM_ST_CFM0 = 7'h0A;
  localparam logic [6:0] GFM_ST_GST0 = 7'h0B;
  localparam logic [6:0] GFM_ST_FAIL0 = 7'h0C;
  localparam logic [6:0] GFM_ST_REF_STEP = 7'h08;

  // effective control functions, lsb first: los, tie, stop, diff, se
  typedef struct packed {
    logic [3:0] se_en;
    logic [7:0] diff_en;
    logic [7:0] stop_clk;
    logic [1:0] tie_clear;
    logic [3:0] ref_los;
  } gfm_eff_t;
  localparam int GFM_NFN = 26;

  // control code for each bit of gfm_eff_t
  localparam logic [6:0] GFM_FN_CODE [GFM_NFN] = '{
    7'h10, 7'h14, 7'h18, 7'h1C,
    7'h20, 7'h28,
    7'h47, 7'h46, 7'h45, 7'h44, 7'h4F, 7'h4E, 7'h4D, 7'h4C,
    7'h60, 7'h62, 7'h64, 7'h66, 7'h68, 7'h6A, 7'h6C, 7'h6E,
    7'h70, 7'h72, 7'h74, 7'h76};

  // software visible configuration, also the one-time image
  typedef struct packed {
    logic [15:0] fail_mask;
    logic [3:0] se_en;
    logic [7:0] diff_en;
    logic [7:0] stop_clk;
    logic [1:0] tie_clear;
    logic [GFM_NPIN-1:0][7:0] pin_cfg;
  } gfm_cfg_t;
  localparam gfm_cfg_t GFM_CFG_RST = '0;

  // reference monitor indicators
  typedef struct packed {
    logic [3:0] guard_soak_timer;
    logic [3:0] coarse_frequency_check;
    logic [3:0] single_cycle_check;
  } gfm_ind_t;
endpackage : gfm_pkg

// File: gfm_props.sv
`timescale 1ns/1ps
`default_nettype none
module gfm_props import gfm_pkg::*; (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset, active low
  input wire logic hsel, // select
  input wire logic [31:0] haddr, // address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write
  input wire logic hready, // bus ready
  input wire logic [31:0] hrdata, // read data
  input wire logic hreadyout, // slave ready
  input wire logic hresp, // response
  input wire logic [7:0] gpio_in, // pin levels
  input wire logic [7:0] gpio_out, // pin drive
  input wire logic [7:0] gpio_oe, // pin enable
  input wire logic device_irq, // interrupt level
  input wire gfm_ind_t ref_ind, // indicators
  input wire gfm_eff_t eff // functions
);
  // taken transfers
  wire logic tk = hsel && hready && htrans[1];
  wire logic wt = tk && hwrite;
  wire logic rt = tk && !hwrite;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_ready_late; $rose(hresetn) |=> !hreadyout; endproperty
  a_ready_late: assert property (p_ready_late) else $error("ready too early");
  property p_ready_on; $past(hresetn) && $past(hresetn, 2) |-> hreadyout; endproperty
  a_ready_on: assert property (p_ready_on) else $error("ready missing");
  property p_zero_wait; tk |=> hreadyout && !hresp; endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("wait or error");
  property p_rdata_idle; !$past(rt) |-> hrdata == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("stray read data");
  property p_unmapped; rt && haddr > 32'h3B |=> hrdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
  property p_eff_hold;
    $past(hresetn, 3) && $stable(gpio_in) && !$past(wt) && !$past(wt, 2) |=> $stable(eff);
  endproperty
  a_eff_hold: assert property (p_eff_hold) else $error("eff moved");
  property p_oe_hold; $past(hresetn, 3) && !$past(wt) && !$past(wt, 2) |=> $stable(gpio_oe);
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("oe moved");
  property p_out_hold;
    $past(hresetn, 3) && $stable(gpio_in) && $stable(device_irq) && $stable(ref_ind)
      && !$past(wt) && !$past(wt, 2) |=> $stable(gpio_out);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("out moved");
endmodule : gfm_props
bind gfm_top gfm_props chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hrdata, .hreadyout, .hresp, .gpio_in, .gpio_out, .gpio_oe, .device_irq, .ref_ind, .eff);
`default_nettype wire

// File: gfm_board.sv
`timescale 1ns/1ps
`default_nettype none
module gfm_board (
  input wire logic [7:0] drv, // board levels
  input wire logic [7:0] gpio_out, // device drive
  input wire logic [7:0] gpio_oe, // device enable
  output logic [7:0] gpio_in // wire levels
);
  // device wins where it drives
  assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & drv);
endmodule : gfm_board
`default_nettype wire

// File: gpio_function_mapper_tb.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_function_mapper_tb import gfm_pkg::*; ;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, device_irq = 0, hreadyout, hresp;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, r, rd;
  logic [1:0] htrans = '0;
  logic [7:0] drv = '0, gpio_in, gpio_out, gpio_oe;
  logic [25:0] e;
  logic [6:0] c;
  logic [7:0] eo;
  logic [6:0] xc [3] = '{7'h00, 7'h12, 7'h61};
  gfm_cfg_t otp = '0;
  gfm_ind_t ref_ind = '0;
  gfm_eff_t eff;
  int n_mismatch = 0, cmp_count = 0;
  gfm_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .otp_image(otp), .gpio_in, .gpio_out,
    .gpio_oe, .device_irq, .ref_ind, .eff);
  gfm_board brd_u (.drv, .gpio_out, .gpio_oe, .gpio_in);
  // clock
  initial forever #10 hclk = ~hclk;
  ////////////////////////////////////////////////////////////
  // one single transfer, waits on ready
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : ahb
  task chk(input string s, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", s, x, g);
    end
  endtask : chk
  task settle;
    repeat (3) @(posedge hclk);
    #1;
  endtask : settle
  // register bits or-ed with the matching pin function
  function logic [25:0] exp_eff(logic [6:0] k, logic lv, logic [25:0] rg);
    exp_eff = rg;
    for (int i = 0; i < GFM_NFN; i++) if (lv && k == GFM_FN_CODE[i]) exp_eff[i] = 1'b1;
  endfunction : exp_eff
  // failure of reference k: indicators and pin input, each gated by its mask bit
  function logic fail_exp(gfm_ind_t ind, int k, logic loss_of_signal_input, logic [3:0] m);
    fail_exp = |({ind.guard_soak_timer[k], ind.coarse_frequency_check[k],
      ind.single_cycle_check[k], loss_of_signal_input} & m);
  endfunction : fail_exp
  task conclude;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #200000;
    n_mismatch++;
    conclude;
  end
  // main sequence
  initial begin
    void'($urandom(13907));
    otp.diff_en = 8'hA5;
    otp.pin_cfg[1] = 8'h80;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(0, GFM_OFF_DIFF, 0, rd);
    chk("image diff", 32'hA5, rd);
    ahb(0, 8'h04, 0, rd);
    chk("image pin1", 32'h80, rd);
    ahb(0, 8'h40, 0, rd);
    chk("unmapped", 0, rd);
    for (int i = 0; i < GFM_NFN + 3; i++) begin
      c = (i < GFM_NFN) ? GFM_FN_CODE[i] : xc[i - GFM_NFN];
      for (int lv = 0; lv < 2; lv++) begin
        r = $urandom;
        ahb(1, GFM_OFF_LOOP, r, rd);
        ahb(1, GFM_OFF_STOP, r >> 2, rd);
        ahb(1, GFM_OFF_DIFF, r >> 10, rd);
        ahb(1, GFM_OFF_SE, r >> 18, rd);
        ahb(1, 8'h0C, {25'h0, c}, rd);
        drv <= (8'($urandom) & 8'hF7) | {4'h0, lv[0], 3'h0};
        e = exp_eff(c, lv[0], {r[21:0], 4'h0});
        settle;
        chk("eff", {6'h0, e}, {6'h0, eff});
        ahb(0, GFM_OFF_EFF, 0, rd);
        chk("eff reg", {6'h0, e}, rd);
      end
    end
    ahb(1, 8'h0C, 32'h10, rd);
    ahb(1, 8'h08, 32'h8C, rd);
    ahb(1, 8'h10, 32'h91, rd);
    ahb(1, 8'h14, 32'h9A, rd);
    ahb(1, 8'h18, 32'hA3, rd);
    ahb(1, 8'h1C, 32'hA4, rd);
    repeat (20) begin
      r = $urandom;
      ahb(1, GFM_OFF_MASK, r, rd);
      drv <= r[23:16];
      device_irq <= r[24];
      ref_ind <= r[31:20];
      settle;
      eo = {fail_exp(ref_ind, 3, 1'b0, r[15:12]), ref_ind.guard_soak_timer[3],
        ref_ind.coarse_frequency_check[2], ref_ind.single_cycle_check[1], 1'b0,
        fail_exp(ref_ind, 0, drv[3], r[3:0]), r[24], 1'b0};
      chk("status", {16'h0, 8'hF6, eo}, {16'h0, gpio_oe, gpio_out});
      ahb(0, GFM_OFF_PIN_IN, 0, rd);
      chk("pin levels", {24'h0, eo[7:4], drv[3], eo[2:1], drv[0]}, rd);
      ahb(0, GFM_OFF_MASK, 0, rd);
      chk("mask", {16'h0, r[15:0]}, rd);
    end
    // second reset in mid-run reloads a changed image
    r = $urandom;
    @(posedge hclk);
    hresetn <= 1'b0;
    otp.stop_clk <= r[7:0];
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(0, 8'h0C, 0, rd);
    chk("reload pin3", 32'h0, rd);
    ahb(0, GFM_OFF_STOP, 0, rd);
    chk("reload stop", {24'h0, r[7:0]}, rd);
    ahb(0, GFM_OFF_EFF, 0, rd);
    e = exp_eff(7'h00, 1'b0, {4'h0, 8'hA5, r[7:0], 6'h0});
    chk("reload eff", {6'h0, e}, rd);
    conclude;
  end
endmodule : gpio_function_mapper_tb
`default_nettype wire
